// ===== rtl/sbr_pkg.sv
// Shared constants, carriers and state types of the serial boot responder.
// Assumes a single 250 MHz system clock and an active-low async reset.
package sbr_pkg;

	// ************************************************************
	// Link and command bytes
	// ************************************************************
	localparam logic [7:0] SBR_SYNC1 = 8'h86; // First matching byte
	localparam logic [7:0] SBR_SYNC2 = 8'h79; // Second matching byte
	localparam logic [7:0] SBR_CMD_SUM = 8'h90; // Checksum output command
	localparam logic [7:0] SBR_CMD_ID = 8'hC0; // Product record command
	localparam logic [7:0] SBR_ERR_FRAME = 8'hA1; // Bad stop bit on command
	localparam logic [7:0] SBR_ERR_NOISE = 8'hA3; // Start bit glitch
	localparam logic [7:0] SBR_ERR_CMD = 8'h63; // Unknown command byte
	localparam logic [7:0] SBR_BLANK_YES = 8'hAA; // Every byte erased
	localparam logic [7:0] SBR_BLANK_NO = 8'h55; // Some byte written
	localparam logic [7:0] SBR_ERASED = 8'hFF; // Value of an erased byte
	localparam logic [7:0] SBR_ZERO_BYTE = 8'h00; // Zero byte

	// ************************************************************
	// Flash range scanned by the checksum pass
	// ************************************************************
	localparam logic [15:0] SBR_FLASH_FIRST = 16'h8000;
	localparam logic [15:0] SBR_FLASH_LAST = 16'hFFFF;
	localparam logic [15:0] SBR_SUM_INIT = 16'h0000;

	// ************************************************************
	// Response sequencing indices
	// ************************************************************
	localparam int SBR_REC_LEN = 21; // Start mark, count and payload
	localparam logic [4:0] SBR_IDX_FIRST = 5'h00; // First response byte
	localparam logic [4:0] SBR_IDX_ONE = 5'h01; // Second response byte
	localparam logic [4:0] SBR_SUM_LAST_IDX = 5'h02; // Blank, high, low
	localparam logic [4:0] SBR_ERR_LAST_IDX = 5'h02; // Three error bytes
	localparam logic [4:0] SBR_ID_REC_LAST = 5'h15; // Last table byte
	localparam logic [4:0] SBR_ID_CS_FIRST = 5'h03; // First summed payload
	localparam logic [4:0] SBR_ID_LAST_IDX = 5'h16; // Record checksum

	// Record table, element 0 goes out first after the 0xC0 echo
	localparam logic [SBR_REC_LEN-1:0][7:0] SBR_ID_RECORD = {
		8'h3F, 8'h08, 8'h00, 8'h60, 8'h00, 8'h00,
		8'hFF, 8'hFF, 8'h00,
		8'h00, 8'h80, 8'h00,
		8'h01,
		8'h80,
		8'h00, 8'h00, 8'h00, 8'hFD,
		8'h03,
		8'h13, 8'h3A
	};

	// ************************************************************
	// Bit timing
	// ************************************************************
	localparam logic [15:0] SBR_BAUD_MIN = 16'h0004; // Shortest bit period
	localparam logic [15:0] SBR_CNT_MAX = 16'hFFFF; // Measure timeout
	localparam logic [15:0] SBR_CNT_ONE = 16'h0001;
	localparam logic [2:0] SBR_AB_FIRST_BIT = 3'h1; // Bit after the 2-bit low
	localparam logic [2:0] SBR_RX_LAST_BIT = 3'h7;
	localparam logic [3:0] SBR_TX_LAST_BIT = 4'h9; // Eight data plus stop
	localparam int SBR_FIFO_DEPTH = 16;
	localparam int SBR_BYTE_W = 8;

	// ************************************************************
	// Carriers and state types
	// ************************************************************
	typedef struct packed {
		logic valid; // One-cycle pulse
		logic ferr; // Stop bit sampled low
		logic noise; // Start bit vanished at mid-bit
		logic [7:0] data;
	} sbr_rx_type;

	typedef enum {S_SYNC1, S_SYNC2, S_CMD, S_SCAN, S_SUM, S_ID, S_ERR,
		S_DEAD} sbr_seq_type;
	typedef enum {RX_IDLE, RX_MEAS, RX_START, RX_BITS, RX_STOP} sbr_rxs_type;
	typedef enum {TX_IDLE, TX_BUSY} sbr_txs_type;

endpackage

// ===== rtl/sbr_fifo.sv
// Synchronous FIFO held in flip-flops with valid/ready on both sides.
// Assumes one clock for both sides and an active-low async reset.
module sbr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	logic [DEPTH-1:0][WIDTH-1:0] mem_q; // Storage
	logic [AW-1:0] wr_q; // Write index
	logic [AW-1:0] rd_q; // Read index
	logic [AW:0] cnt_q; // Fill level
	logic push;
	logic pop;

	// Honest flags straight from the fill level
	assign in_ready = (cnt_q != FULL_CNT);
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// ************************************************************
	// Storage write
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mem_q <= '0;
		end else if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// ************************************************************
	// Pointers and level
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

endmodule // sbr_fifo

// ===== rtl/sbr_responder.sv
// Serial boot responder: autobaud handshake, checksum and product record.
// Assumes rxd comes from a pin and the flash answers one cycle after a read.
// ************************************************************
// Responder top
// ************************************************************
// Notes on behaviour
// - 0x86 sets rate; echo it, else silence
// - Autobaud first byte; later bytes at that rate
// - 0x79 echoed when matched, else silence
// - 0x90 accepted without any echo byte
// - Rejected command: three error bytes, then idle
// - Blank byte 0xAA if all erased, else 0x55
// - Checksum high byte then low byte
// - After last byte, wait next command
// - 0xC0 accepted and echoed
// - Record starts 0x3A then count 0x13
// - First payload byte 0x03, address width
// - Eighth byte ROM size code 0x80
// - Writable range 008000 to 00FFFF, upper first
// - Last byte negates payload byte sum
module sbr_responder
	import sbr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic rxd,
	output logic txd,
	output logic flash_rd,
	output logic [15:0] flash_addr,
	input wire logic [7:0] flash_rdata,
	output logic dead
);

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	// ************************************************************
	// Declarations
	// ************************************************************
	logic rx_s1_q; // First synchroniser stage
	logic rx_s2_q; // Synchronised line level
	sbr_rxs_type rx_st_q; // Receiver state
	logic [15:0] baud_q; // Bit period in cycles
	logic [15:0] rcnt_q; // Receiver cycle count
	logic [2:0] rbit_q; // Receive bit index
	logic [7:0] rsh_q; // Received bits
	logic ab_q; // Frame aligned by measurement
	sbr_rx_type rx_q; // Received byte pulse
	logic [15:0] half_w; // Mid-bit sample point
	sbr_txs_type tx_st_q; // Transmitter state
	logic [15:0] tcnt_q; // Transmit cycle count
	logic [3:0] tbit_q; // Transmit bit index
	logic [8:0] tsh_q; // Data and stop bit
	logic txd_q; // Line driver
	sbr_seq_type seq_q; // Exchange sequencer
	logic [4:0] idx_q; // Response byte index
	logic echo_v_q; // Echo byte waiting
	logic [7:0] echo_d_q; // Echo byte value
	logic [7:0] err_q; // Error byte to repeat
	logic [7:0] csum_q; // Record payload sum
	logic [15:0] addr_q; // Scan address
	logic rd_q; // Scan read strobe
	logic vld_q; // Flash data valid
	logic last_q; // Valid data is the last one
	logic [15:0] sum_q; // Flash checksum
	logic blank_q; // Every scanned byte erased
	logic push_v; // Byte offered to the FIFO
	logic [7:0] push_d;
	logic push_rdy;
	logic push_fire;
	logic fo_valid; // FIFO head present
	logic [7:0] fo_data;
	logic fo_ready;
	logic rx_good; // Clean byte received
	logic scan_go; // Checksum pass starts

	assign half_w = {1'b0, baud_q[15:1]};
	assign rx_good = rx_q.valid && !rx_q.ferr && !rx_q.noise;
	assign scan_go = (seq_q == S_CMD) && rx_good && (rx_q.data == SBR_CMD_SUM);
	assign txd = txd_q;
	assign flash_rd = rd_q;
	assign flash_addr = addr_q;
	assign dead = (seq_q == S_DEAD);

	// ************************************************************
	// Receiver
	// ************************************************************
	// Two stages before any logic looks at the pin
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
		end else begin
			rx_s1_q <= rxd;
			rx_s2_q <= rx_s1_q;
		end
	end

	// Frame receiver; while waiting for 0x86 it measures the leading low run
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rx_st_q <= RX_IDLE;
			baud_q <= SBR_CNT_MAX;
			rcnt_q <= '0;
			rbit_q <= '0;
			rsh_q <= '0;
			ab_q <= 1'b0;
			rx_q <= '0;
		end else begin
			rx_q.valid <= 1'b0;
			rcnt_q <= rcnt_q + SBR_CNT_ONE;
			case (rx_st_q)
				RX_IDLE: begin
					rcnt_q <= SBR_CNT_ONE;
					ab_q <= 1'b0;
					if (!rx_s2_q) begin
						// Start and bit 0 of 0x86 form one two-bit low run
						rx_st_q <= (seq_q == S_SYNC1) ? RX_MEAS : RX_START;
					end
				end
				RX_MEAS: begin
					if (rcnt_q == SBR_CNT_MAX) begin
						rx_st_q <= RX_IDLE; // Line stuck low, no answer
					end else if (rx_s2_q) begin
						// Half the run is one bit; reused for the whole exchange
						baud_q <= {1'b0, rcnt_q[15:1]};
						rcnt_q <= '0;
						rbit_q <= SBR_AB_FIRST_BIT;
						rsh_q <= '0;
						ab_q <= 1'b1;
						rx_st_q <= (rcnt_q[15:1] < SBR_BAUD_MIN) ? RX_IDLE
							: RX_START;
					end
				end
				RX_START: begin
					if (rcnt_q == half_w) begin
						rcnt_q <= '0;
						if (ab_q) begin
							// Mid point of bit 1, already past the start bit
							rsh_q[rbit_q] <= rx_s2_q;
							rbit_q <= rbit_q + 3'h1;
							rx_st_q <= RX_BITS;
						end else if (!rx_s2_q) begin
							rbit_q <= '0;
							rx_st_q <= RX_BITS;
						end else begin
							// Glitch: reported so a command can be refused
							rx_q <= '{valid: 1'b1, ferr: 1'b0, noise: 1'b1,
								data: SBR_ZERO_BYTE};
							rx_st_q <= RX_IDLE;
						end
					end
				end
				RX_BITS: begin
					if (rcnt_q == baud_q - SBR_CNT_ONE) begin
						rcnt_q <= '0;
						rsh_q[rbit_q] <= rx_s2_q;
						if (rbit_q == SBR_RX_LAST_BIT) begin
							rx_st_q <= RX_STOP;
						end else begin
							rbit_q <= rbit_q + 3'h1;
						end
					end
				end
				RX_STOP: begin
					if (rcnt_q == baud_q - SBR_CNT_ONE) begin
						rx_q <= '{valid: 1'b1, ferr: !rx_s2_q, noise: 1'b0,
							data: rsh_q};
						rx_st_q <= RX_IDLE;
					end
				end
				default: rx_st_q <= RX_IDLE;
			endcase
		end
	end

	a_rate_kept: assert property ((rx_st_q != RX_MEAS) |=> $stable(baud_q))
		else $error("bit period changed outside measurement");

	// ************************************************************
	// Transmit buffer and transmitter
	// ************************************************************
	// The FIFO lets the sequencer run ahead of the slow line
	sbr_fifo #(
		.WIDTH(SBR_BYTE_W),
		.DEPTH(SBR_FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.in_valid(push_v),
		.in_ready(push_rdy),
		.in_data(push_d),
		.out_valid(fo_valid),
		.out_ready(fo_ready),
		.out_data(fo_data)
	);

	assign fo_ready = (tx_st_q == TX_IDLE);
	assign push_fire = push_v && push_rdy;

	// Serialiser at the measured rate, start bit out on the load edge
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tx_st_q <= TX_IDLE;
			tcnt_q <= '0;
			tbit_q <= '0;
			tsh_q <= '0;
			txd_q <= 1'b1;
		end else begin
			case (tx_st_q)
				TX_IDLE: begin
					txd_q <= 1'b1;
					if (fo_valid) begin
						txd_q <= 1'b0;
						tsh_q <= {1'b1, fo_data};
						tcnt_q <= '0;
						tbit_q <= '0;
						tx_st_q <= TX_BUSY;
					end
				end
				TX_BUSY: begin
					tcnt_q <= tcnt_q + SBR_CNT_ONE;
					if (tcnt_q == baud_q - SBR_CNT_ONE) begin
						tcnt_q <= '0;
						if (tbit_q == SBR_TX_LAST_BIT) begin
							txd_q <= 1'b1;
							tx_st_q <= TX_IDLE;
						end else begin
							txd_q <= tsh_q[0];
							tsh_q <= {1'b1, tsh_q[8:1]};
							tbit_q <= tbit_q + 4'h1;
						end
					end
				end
				default: tx_st_q <= TX_IDLE;
			endcase
		end
	end

	// ************************************************************
	// Flash checksum pass
	// ************************************************************
	// One read per cycle; sum and blank check share the pass
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			addr_q <= SBR_FLASH_FIRST;
			rd_q <= 1'b0;
			vld_q <= 1'b0;
			last_q <= 1'b0;
			sum_q <= SBR_SUM_INIT;
			blank_q <= 1'b1;
		end else begin
			vld_q <= rd_q;
			last_q <= rd_q && (addr_q == SBR_FLASH_LAST);
			if (scan_go) begin
				addr_q <= SBR_FLASH_FIRST;
				rd_q <= 1'b1;
				sum_q <= SBR_SUM_INIT;
				blank_q <= 1'b1;
			end else begin
				if (rd_q) begin
					if (addr_q == SBR_FLASH_LAST) begin
						rd_q <= 1'b0;
					end else begin
						addr_q <= addr_q + SBR_CNT_ONE;
					end
				end
				if (vld_q) begin
					sum_q <= sum_q + {8'h00, flash_rdata};
					blank_q <= blank_q && (flash_rdata == SBR_ERASED);
				end
			end
		end
	end

	// ************************************************************
	// Response byte selection
	// ************************************************************
	// Echoes go first; response states wait behind them
	always_comb begin
		push_v = 1'b0;
		push_d = SBR_ZERO_BYTE;
		if (echo_v_q) begin
			push_v = 1'b1;
			push_d = echo_d_q;
		end else begin
			case (seq_q)
				S_SUM: begin
					push_v = 1'b1;
					if (idx_q == SBR_IDX_FIRST) begin
						push_d = blank_q ? SBR_BLANK_YES : SBR_BLANK_NO;
					end else if (idx_q == SBR_IDX_ONE) begin
						push_d = sum_q[15:8];
					end else begin
						push_d = sum_q[7:0];
					end
				end
				S_ID: begin
					push_v = 1'b1;
					if (idx_q == SBR_IDX_FIRST) begin
						push_d = SBR_CMD_ID;
					end else if (idx_q == SBR_ID_LAST_IDX) begin
						push_d = ~csum_q + 8'h01;
					end else begin
						push_d = SBR_ID_RECORD[idx_q - SBR_IDX_ONE];
					end
				end
				S_ERR: begin
					push_v = 1'b1;
					push_d = err_q;
				end
				default: push_v = 1'b0;
			endcase
		end
	end

	// ************************************************************
	// Exchange sequencer
	// ************************************************************
	// Bytes arriving while a response is busy are dropped
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			seq_q <= S_SYNC1;
			idx_q <= '0;
			echo_v_q <= 1'b0;
			echo_d_q <= '0;
			err_q <= SBR_ERR_CMD;
		end else begin
			if (push_fire && echo_v_q) begin
				echo_v_q <= 1'b0;
			end
			case (seq_q)
				S_SYNC1: begin
					if (rx_good && rx_q.data == SBR_SYNC1) begin
						echo_v_q <= 1'b1;
						echo_d_q <= SBR_SYNC1;
						seq_q <= S_SYNC2;
					end
				end
				S_SYNC2: begin
					if (rx_q.valid) begin
						if (rx_good && rx_q.data == SBR_SYNC2) begin
							echo_v_q <= 1'b1;
							echo_d_q <= SBR_SYNC2;
							seq_q <= S_CMD;
						end else begin
							seq_q <= S_SYNC1;
						end
					end
				end
				S_CMD: begin
					idx_q <= SBR_IDX_FIRST;
					if (rx_q.valid) begin
						if (rx_q.noise) begin
							err_q <= SBR_ERR_NOISE;
							seq_q <= S_ERR;
						end else if (rx_q.ferr) begin
							err_q <= SBR_ERR_FRAME;
							seq_q <= S_ERR;
						end else if (rx_q.data == SBR_CMD_SUM) begin
							seq_q <= S_SCAN;
						end else if (rx_q.data == SBR_CMD_ID) begin
							seq_q <= S_ID;
						end else begin
							err_q <= SBR_ERR_CMD;
							seq_q <= S_ERR;
						end
					end
				end
				S_SCAN: begin
					if (vld_q && last_q) begin
						seq_q <= S_SUM;
					end
				end
				S_SUM: begin
					if (push_fire && !echo_v_q) begin
						idx_q <= idx_q + SBR_IDX_ONE;
						if (idx_q == SBR_SUM_LAST_IDX) begin
							seq_q <= S_CMD;
						end
					end
				end
				S_ID: begin
					if (push_fire && !echo_v_q) begin
						idx_q <= idx_q + SBR_IDX_ONE;
						if (idx_q == SBR_ID_LAST_IDX) begin
							seq_q <= S_CMD;
						end
					end
				end
				S_ERR: begin
					if (push_fire && !echo_v_q) begin
						idx_q <= idx_q + SBR_IDX_ONE;
						if (idx_q == SBR_ERR_LAST_IDX) begin
							seq_q <= S_DEAD;
						end
					end
				end
				S_DEAD: seq_q <= S_DEAD;
				default: seq_q <= S_SYNC1;
			endcase
		end
	end

	// Sum of the nineteen payload bytes as they leave
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			csum_q <= '0;
		end else if (seq_q != S_ID) begin
			csum_q <= '0;
		end else if (push_fire && !echo_v_q && idx_q >= SBR_ID_CS_FIRST
			&& idx_q <= SBR_ID_REC_LAST) begin
			csum_q <= csum_q + push_d;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	a_sync1_echo: assert property ((seq_q == S_SYNC1 && rx_good &&
		rx_q.data == SBR_SYNC1) |=> (echo_v_q && echo_d_q == SBR_SYNC1
		&& seq_q == S_SYNC2))
		else $error("first matching byte not echoed");
	a_sync1_quiet: assert property ((seq_q == S_SYNC1 && !echo_v_q &&
		rx_q.valid && rx_q.data != SBR_SYNC1) |=> (!echo_v_q &&
		seq_q == S_SYNC1))
		else $error("bad first byte produced output");
	a_sync2_echo: assert property ((seq_q == S_SYNC2 && rx_good &&
		rx_q.data == SBR_SYNC2) |=> (echo_v_q && echo_d_q == SBR_SYNC2
		&& seq_q == S_CMD))
		else $error("second matching byte not echoed");
	a_sum_no_echo: assert property (scan_go |=>
		(seq_q == S_SCAN && rd_q && !push_v) ##1 !push_v)
		else $error("checksum command echoed");
	a_err_idle: assert property ((seq_q == S_ERR && push_fire && !echo_v_q
		&& idx_q == SBR_ERR_LAST_IDX) |=> (seq_q == S_DEAD && !push_v)
		##1 (seq_q == S_DEAD && !push_v))
		else $error("no idle after error bytes");
	a_err_code: assert property ((seq_q == S_ERR && !echo_v_q) |->
		(push_d == err_q && (err_q == SBR_ERR_FRAME ||
		err_q == SBR_ERR_NOISE || err_q == SBR_ERR_CMD)) ##1
		(seq_q != S_ERR || $stable(push_d)))
		else $error("error byte changed or invalid");
	a_blank_byte: assert property ((seq_q == S_SCAN && vld_q &&
		flash_rdata != SBR_ERASED) |=> (!blank_q ##1 !blank_q))
		else $error("written byte left blank flag set");
	a_sum_order: assert property ((seq_q == S_SUM && push_fire &&
		idx_q == SBR_IDX_ONE) |-> (push_d == sum_q[15:8]) ##1
		(idx_q == SBR_SUM_LAST_IDX && push_d == sum_q[7:0]))
		else $error("checksum bytes out of order");
	a_back_cmd: assert property ((push_fire && !echo_v_q &&
		((seq_q == S_SUM && idx_q == SBR_SUM_LAST_IDX) ||
		(seq_q == S_ID && idx_q == SBR_ID_LAST_IDX))) |=> seq_q == S_CMD)
		else $error("no return to command wait");
	a_id_echo: assert property ((seq_q == S_CMD && rx_good &&
		rx_q.data == SBR_CMD_ID) |=> (seq_q == S_ID &&
		idx_q == SBR_IDX_FIRST && push_d == SBR_CMD_ID))
		else $error("record command not echoed");
	a_id_check: assert property ((seq_q == S_ID && !echo_v_q &&
		idx_q == SBR_ID_LAST_IDX) |-> ((push_d + csum_q) == SBR_ZERO_BYTE))
		else $error("record checksum wrong");

endmodule // sbr_responder

// ===== tb/sbr_ctrl_model.sv
// Controller model: sends and takes 8N1 bytes at a fixed bit period.
// Assumes the responder samples rxd on clk_sys and idles txd high.
module sbr_ctrl_model #(
	parameter int P = 8
) (
	input wire logic clk_sys,
	output logic rxd,
	input wire logic txd
);
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************************
	// Line driver and receiver
	// ************************************************************
	initial rxd = 1'b1; // Line idles high

	// Mode 0 sends clean, mode 1 drops the stop bit, mode 2 fakes a start
	task automatic send(input logic [7:0] b, input int mode);
		logic [9:0] f;
		f = {mode != 1, b, 1'b0};
		if (mode == 2) begin
			@(negedge clk_sys) rxd <= 1'b0;
			repeat (2) @(negedge clk_sys);
			// Back at once: the refusal bytes follow within a few cycles
			rxd <= 1'b1;
		end else begin
			for (int i = 0; i < 10; i++) begin
				@(negedge clk_sys) rxd <= f[i];
				// Stop cut short so an echo is never missed
				repeat ((i == 9) ? P / 2 : P - 1) @(negedge clk_sys);
			end
		end
		@(negedge clk_sys) rxd <= 1'b1;
	endtask

	// Waits up to lim cycles for a start bit; unknown byte on timeout
	task automatic recv(output logic [7:0] b, input int lim);
		int n;
		n = 0;
		b = 8'h00;
		while (txd !== 1'b0 && n < lim) begin
			@(negedge clk_sys);
			n++;
		end
		repeat (P / 2) @(negedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			repeat (P) @(negedge clk_sys);
			b[i] = txd;
		end
		repeat (P) @(negedge clk_sys);
		if (n >= lim) begin
			b = 'x;
		end
	endtask
endmodule // sbr_ctrl_model

// ===== tb/tb_serial_boot_sum_and_id_responder.sv
// Self-checking bench of the serial boot responder.
// Assumes a one-cycle flash model and a controller model on the link.
module tb_serial_boot_sum_and_id_responder
	import sbr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int P = 8; // Bit period in clocks, above the minimum
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic rxd, txd, flash_rd, dead;
	logic [15:0] flash_addr;
	logic [7:0] flash_rdata = 8'h00;
	logic [7:0] mem [32768];
	logic [14:0] rd_addr_q = 15'h0000;
	logic [31:0] lfsr_q = 32'h000166AA;
	logic [7:0] got;
	logic quiet; // Line stayed high through a whole watch
	int bad_count = 0;
	int check_count = 0;
	int cycles = 0;
	logic [7:0] rec [21] = '{8'h3A, 8'h13, 8'h03, 8'hFD, 8'h00, 8'h00,
		8'h00, 8'h80, 8'h01, 8'h00, 8'h80, 8'h00, 8'h00, 8'hFF, 8'hFF,
		8'h00, 8'h00, 8'h60, 8'h00, 8'h08, 8'h3F};

	// ************************************************************
	// Clock, flash model and hang guard
	// ************************************************************
	always #2 clk_sys = ~clk_sys;
	// Data lands on the falling edge, ready at the next rising one
	always @(posedge clk_sys) if (flash_rd) rd_addr_q <= flash_addr[14:0];
	always @(negedge clk_sys) flash_rdata <= mem[rd_addr_q];
	// Two scans of 32768 reads plus serial traffic fit well below this
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 95000) begin
			bad_count++;
			conclude();
		end
	end

	sbr_ctrl_model #(.P(P)) ctl (.clk_sys(clk_sys), .rxd(rxd), .txd(txd));
	sbr_responder dut_u (.clk_sys(clk_sys), .rstn(rstn), .rxd(rxd),
		.txd(txd), .flash_rd(flash_rd), .flash_addr(flash_addr),
		.flash_rdata(flash_rdata), .dead(dead));

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Blank flag above a 16-bit wrapping sum of the whole range
	function automatic logic [16:0] sum_exp();
		logic [15:0] s;
		logic bl;
		s = 16'h0000;
		bl = 1'b1;
		for (int i = 0; i < 32768; i++) begin
			s += {8'h00, mem[i]};
			bl &= (mem[i] == 8'hFF);
		end
		return {bl, s};
	endfunction

	task automatic chk(input string what, input logic [7:0] exp, g);
		check_count++;
		if (g !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, g);
		end
	endtask

	task automatic conclude();
		if (bad_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Watches the line for twelve bit periods; high throughout is silence
	task automatic hush(output logic q);
		q = 1'b1;
		repeat (12 * P) begin
			@(negedge clk_sys);
			q &= txd;
		end
	endtask

	// Reset, a refused byte at each matching step, then both matches
	task automatic start_up();
		@(negedge clk_sys) rstn <= 1'b0;
		repeat (20) @(negedge clk_sys);
		rstn <= 1'b1;
		repeat (4) @(negedge clk_sys);
		// Same two-bit low run as the first match, but a wrong value
		ctl.send(8'h06, 0);
		hush(quiet);
		chk("no_echo1", 8'h01, {7'h00, quiet});
		ctl.send(8'h86, 0);
		ctl.recv(got, 400);
		chk("echo1", 8'h86, got);
		ctl.send(8'h7A, 0);
		hush(quiet);
		chk("no_echo2", 8'h01, {7'h00, quiet});
		// A refused second byte sends the device back to rate matching
		ctl.send(8'h86, 0);
		ctl.recv(got, 400);
		chk("echo1", 8'h86, got);
		ctl.send(8'h79, 0);
		ctl.recv(got, 400);
		chk("echo2", 8'h79, got);
	endtask

	// No echo: the first byte back is already the blank flag
	task automatic sum_cmd(input logic [16:0] e);
		ctl.send(8'h90, 0);
		ctl.recv(got, 40000);
		chk("blank", e[16] ? 8'hAA : 8'h55, got);
		ctl.recv(got, 400);
		chk("sum_hi", e[15:8], got);
		ctl.recv(got, 400);
		chk("sum_lo", e[7:0], got);
	endtask

	task automatic id_cmd();
		logic [7:0] cs;
		cs = 8'h00;
		ctl.send(8'hC0, 0);
		ctl.recv(got, 400);
		chk("id_echo", 8'hC0, got);
		for (int i = 0; i < 21; i++) begin
			ctl.recv(got, 400);
			chk("record", rec[i], got);
			if (i > 1) begin
				cs -= rec[i];
			end
		end
		ctl.recv(got, 400);
		chk("rec_sum", cs, got);
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		logic [7:0] b;
		logic [7:0] ecode [3];
		ecode = '{SBR_ERR_CMD, SBR_ERR_FRAME, SBR_ERR_NOISE};
		for (int i = 0; i < 32768; i++) begin
			lfsr_q = lfsr_next(lfsr_q);
			mem[i] = lfsr_q[7:0];
		end
		start_up();
		sum_cmd(sum_exp());
		id_cmd();
		// Erased part: every byte at the erased value
		for (int i = 0; i < 32768; i++) mem[i] = 8'hFF;
		sum_cmd(sum_exp());
		// Unknown value, low stop bit and start glitch, each from reset
		for (int k = 0; k < 3; k++) begin
			start_up();
			lfsr_q = lfsr_next(lfsr_q);
			b = lfsr_q[7:0];
			if (b == 8'h90 || b == 8'hC0) begin
				b = b ^ 8'h01;
			end
			ctl.send(b, k);
			for (int j = 0; j < 3; j++) begin
				ctl.recv(got, 400);
				chk("err_byte", ecode[k], got);
			end
			repeat (4 * P) @(negedge clk_sys);
			chk("dead", 8'h01, {7'h00, dead});
			// Once idle, a valid command draws no answer
			ctl.send(8'hC0, 0);
			hush(quiet);
			chk("quiet", 8'h01, {7'h00, quiet});
		end
		conclude();
	end
endmodule // tb_serial_boot_sum_and_id_responder
